// ### include/nfc_pkg.sv
// Package with command codes, status fields, timing constants and register map of the controller.
package nfc_pkg;

  // ****************************************************************
  // Device command codes
  // ****************************************************************
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_SIGNATURE = 8'h90;
  localparam logic [7:0] SIG_ADDR = 8'h00;

  // ****************************************************************
  // Status byte fields
  // ****************************************************************
  localparam int ST_UNPROT_BIT = 7;
  localparam int ST_IDLE_BIT = 6;
  localparam int ST_FAIL_BIT = 0;

  // Erase address: A14..A25 select the block, the last cycle keeps I/O2..I/O7 low.
  localparam int BLOCK_W = 12;
  localparam logic [5:0] ROW_PAD = 6'h00;
  localparam logic [4:0] IGNORED_ROW = 5'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 100;
  localparam int STROBE_NS = 50;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_BUSY_ERASE_US = 500;
  localparam int TIMEOUT_US = 4000;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  localparam int CNT_W = 20;

  // ****************************************************************
  // Controller register map
  // ****************************************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_BLOCK = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_RESULT = 4'h3;
  localparam logic [3:0] REG_IDENT = 4'h4;

  // Operation codes written to the control register.
  localparam logic [1:0] OP_ERASE = 2'h0;
  localparam logic [1:0] OP_RESET = 2'h1;
  localparam logic [1:0] OP_STATUS = 2'h2;
  localparam logic [1:0] OP_SIGNATURE = 2'h3;

  typedef enum logic [1:0] {
    PH_CMD,
    PH_ADDR,
    PH_READ
  } nfc_phase_t;

endpackage : nfc_pkg

// ### include/nfc_strobe_if.sv
// Interface between the sequencer and the pin strobe engine.
interface nfc_strobe_if;
  import nfc_pkg::*;
  logic start;
  nfc_phase_t phase;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;

  modport seq(output start, output phase, output wdata, input done, input rdata);
  modport eng(input start, input phase, input wdata, output done, output rdata);
endinterface : nfc_strobe_if

// ### core/nfc_strobe.sv
// Pin strobe engine: one command, address or read cycle on the flash bus.
module nfc_strobe (
  input wire logic core_clk,
  input wire logic rst,
  nfc_strobe_if.eng sif,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic io_oe,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n
);
  import nfc_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic busy_q;
  logic low_q;
  logic done_q;
  logic [7:0] rdata_q;
  wire is_read = (sif.phase == PH_READ);
  wire cnt_zero = (cnt_q == '0);

  assign sif.done = done_q;
  assign sif.rdata = rdata_q;

  // Each cycle drives the strobe low for a half period, then high again.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      low_q <= 1'b0;
      done_q <= 1'b0;
      cnt_q <= '0;
      rdata_q <= 8'h00;
      io_out <= 8'h00;
      io_oe <= 1'b0;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      re_n <= 1'b1;
    end else begin
      done_q <= 1'b0;
      if (!busy_q && sif.start) begin
        busy_q <= 1'b1;
        low_q <= 1'b1;
        cnt_q <= CNT_W'(STROBE_CYC);
        cle <= (sif.phase == PH_CMD);
        ale <= (sif.phase == PH_ADDR);
        io_out <= sif.wdata;
        io_oe <= !is_read;
        we_n <= is_read;
        re_n <= !is_read;
      end else if (busy_q && cnt_zero && low_q) begin
        low_q <= 1'b0;
        cnt_q <= CNT_W'(STROBE_CYC);
        we_n <= 1'b1;
        re_n <= 1'b1;
        if (!we_n) begin
          rdata_q <= rdata_q;
        end else begin
          rdata_q <= io_in; // Sample just before the rising read edge.
        end
      end else if (busy_q && cnt_zero) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
        io_oe <= 1'b0;
        cle <= 1'b0;
        ale <= 1'b0;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : nfc_strobe

// ### core/nfc_ctrl.sv
// Host controller issuing erase, reset, status and signature sequences to a NAND flash.

// Operation
// - Erase is setup command, three address cycles, then confirm command.
// - Erase address skips column cycle; A14..A25 select block, A9..A13 ignored.
// - Host drives I/O2..I/O7 low in the last erase address cycle.
// - Status mode stays until a new command; reissue read to resume.
// - Status bits 5 to 1 are reserved and not interpreted by host.
// - Signature read is command then a single zero address cycle.
// - Copy-back source and target pages share the top row address bits.
// - A block is factory-bad when its marker spare data is not all ones.
// - Bad-block markers must be read before any erase.
// - Host applies one-bit-correct, two-bit-detect ECC per 512 bytes.
module nfc_ctrl #(
  parameter int TIMEOUT_CYCLES = nfc_pkg::TIMEOUT_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [nfc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic io_oe,
  output logic cle,
  output logic ale,
  output logic ce_n,
  output logic we_n,
  output logic re_n,
  input wire logic rb
);
  import nfc_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE,
    S_ISSUE,
    S_WAIT_STROBE,
    S_WAIT_BUSY,
    S_WAIT_READY,
    S_DONE
  } nfc_state_t;

  nfc_strobe_if sif ();

  nfc_state_t state_q;
  logic [1:0] op_q;
  logic [2:0] step_q;
  logic [BLOCK_W-1:0] block_q;
  logic [7:0] status_q;
  logic [7:0] maker_q;
  logic [7:0] dev_q;
  logic busy_q;
  logic fail_q;
  logic timeout_q;
  logic [31:0] wait_q;
  logic start_q;
  nfc_phase_t phase_q;
  logic [7:0] wdata_q;
  logic [31:0] rdata_q;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  // Only four sequences exist; marker reads and error correction stay with software.
  wire wr_ctrl = reg_wr && (reg_addr == REG_CTRL) && !busy_q;
  wire wr_block = reg_wr && (reg_addr == REG_BLOCK) && !busy_q;
  wire [31:0] rd_status = {29'h0, timeout_q, fail_q, busy_q};
  wire [31:0] rd_result = {24'h0, status_q};
  wire [31:0] rd_ident = {16'h0, dev_q, maker_q};
  wire [31:0] rd_mux = (reg_addr == REG_CTRL) ? {30'h0, op_q} :
                       (reg_addr == REG_BLOCK) ? {20'h0, block_q} :
                       (reg_addr == REG_STATUS) ? rd_status :
                       (reg_addr == REG_RESULT) ? rd_result :
                       (reg_addr == REG_IDENT) ? rd_ident : 32'h0;
  wire status_fail = status_q[ST_FAIL_BIT];
  wire status_locked = !status_q[ST_UNPROT_BIT];

  // ****************************************************************
  // Sequence tables
  // ****************************************************************
  // Index of the last bus cycle each operation issues (one less than the cycle count).
  wire [2:0] last_step = (op_q == OP_ERASE) ? 3'h4 :
                         (op_q == OP_RESET) ? 3'h0 :
                         (op_q == OP_STATUS) ? 3'h1 : 3'h3;
  // Erase row cycles carry only block bits; the column cycle is skipped.
  wire [7:0] erase_byte = (step_q == 3'h1) ? {block_q[2:0], IGNORED_ROW} :
                          (step_q == 3'h2) ? block_q[10:3] :
                          {ROW_PAD, 1'b0, block_q[11]};
  wire [7:0] first_cmd = (op_q == OP_ERASE) ? CMD_ERASE_SETUP :
                         (op_q == OP_RESET) ? CMD_RESET :
                         (op_q == OP_STATUS) ? CMD_STATUS : CMD_SIGNATURE;
  wire [7:0] cur_byte = (step_q == 3'h0) ? first_cmd :
                        (op_q == OP_ERASE && step_q == 3'h4) ? CMD_ERASE_CONFIRM :
                        (op_q == OP_ERASE) ? erase_byte : SIG_ADDR;
  wire is_cmd = (step_q == 3'h0) || (op_q == OP_ERASE && step_q == 3'h4);
  wire is_read = (op_q == OP_STATUS && step_q == 3'h1) ||
                 (op_q == OP_SIGNATURE && step_q >= 3'h2);
  wire [2:0] step_next = step_q + 3'h1;
  wire waits_busy = (op_q == OP_ERASE) || (op_q == OP_RESET);
  wire timed_out = (wait_q >= TIMEOUT_CYCLES);

  assign sif.start = start_q;
  assign sif.phase = phase_q;
  assign sif.wdata = wdata_q;
  assign reg_rdata = rdata_q;

  nfc_strobe u_strobe (
    .core_clk(core_clk),
    .rst(rst),
    .sif(sif),
    .io_in(io_in),
    .io_out(io_out),
    .io_oe(io_oe),
    .cle(cle),
    .ale(ale),
    .we_n(we_n),
    .re_n(re_n)
  );

  // ****************************************************************
  // Register file and read port
  // ****************************************************************
  // Software writes the block, then an operation code that starts the sequence.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0;
      block_q <= '0;
      op_q <= OP_STATUS;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 32'h0;
      if (wr_block) begin
        block_q <= reg_wdata[BLOCK_W-1:0];
      end
      if (wr_ctrl) begin
        op_q <= reg_wdata[1:0];
      end
    end
  end

  // Sequencer steps through the cycles and then, for erase and reset only, waits on ready/busy.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      step_q <= 3'h0;
      busy_q <= 1'b0;
      fail_q <= 1'b0;
      timeout_q <= 1'b0;
      start_q <= 1'b0;
      phase_q <= PH_CMD;
      wdata_q <= 8'h00;
      status_q <= 8'h00;
      maker_q <= 8'h00;
      dev_q <= 8'h00;
      wait_q <= 32'h0;
      ce_n <= 1'b1;
    end else begin
      start_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (wr_ctrl) begin
            busy_q <= 1'b1;
            timeout_q <= 1'b0;
            step_q <= 3'h0;
            ce_n <= 1'b0;
            state_q <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          start_q <= 1'b1;
          wdata_q <= cur_byte;
          phase_q <= is_read ? PH_READ : (is_cmd ? PH_CMD : PH_ADDR);
          state_q <= S_WAIT_STROBE;
        end
        S_WAIT_STROBE: begin
          if (sif.done) begin
            if (op_q == OP_STATUS && step_q == 3'h1) begin
              status_q <= sif.rdata;
            end
            if (op_q == OP_SIGNATURE && step_q == 3'h2) begin
              maker_q <= sif.rdata;
            end
            if (op_q == OP_SIGNATURE && step_q == 3'h3) begin
              dev_q <= sif.rdata;
            end
            if (step_q == last_step) begin
              wait_q <= 32'h0;
              state_q <= waits_busy ? S_WAIT_BUSY : S_DONE;
            end else begin
              step_q <= step_next;
              state_q <= S_ISSUE;
            end
          end
        end
        S_WAIT_BUSY: begin
          wait_q <= wait_q + 32'h1;
          if (!rb || wait_q >= 32'(STROBE_CYC)) begin
            state_q <= S_WAIT_READY; // A skipped reset never drops ready/busy.
          end
        end
        S_WAIT_READY: begin
          wait_q <= wait_q + 32'h1;
          if (rb || timed_out) begin
            timeout_q <= timed_out && !rb;
            state_q <= S_DONE;
          end
        end
        S_DONE: begin
          fail_q <= (op_q == OP_STATUS) && (status_fail || status_locked);
          busy_q <= 1'b0;
          ce_n <= 1'b1;
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule : nfc_ctrl

// ### testbench/nfc_ctrl_props.sv
// Checker on the flash pins and register port of the controller.
module nfc_ctrl_props #(parameter int TIMEOUT_CYCLES = 2000) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [7:0] io_out,
  input wire logic io_oe,
  input wire logic cle,
  input wire logic ale,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic re_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import nfc_pkg::*;
  logic [1:0] na_q;
  logic [7:0] cmd_q;
  logic we_n_d;
  logic cle_d;
  logic ale_d;
  logic [7:0] io_last_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Tracks the last command byte and the address cycles finished after it.
  // Plain history flops keep the edge detection free of any clock inference.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      na_q <= 2'h0;
      cmd_q <= 8'h00;
      we_n_d <= 1'b1;
      cle_d <= 1'b0;
      ale_d <= 1'b0;
      io_last_q <= 8'h00;
    end else begin
      we_n_d <= we_n;
      cle_d <= cle;
      ale_d <= ale;
      io_last_q <= io_out;
      if (we_n && !we_n_d && cle_d) begin
        na_q <= 2'h0;
        cmd_q <= io_last_q;
      end else if (we_n && !we_n_d && ale_d) begin
        na_q <= na_q + 2'h1;
      end
    end
  end
  sequence s_strobe_low;
    !we_n [*5];
  endsequence
  sequence s_third_addr;
    ale && !we_n && na_q == 2'h2;
  endsequence
  a_reset_idle: assert property (disable iff (1'b0) rst |-> ce_n && we_n && re_n && !io_oe)
    else $error("flash pins not idle in reset");
  a_rdata_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  a_we_width: assert property ($fell(we_n) |-> s_strobe_low)
    else $error("write strobe too short");
  a_ce_low: assert property (!we_n || !re_n |-> !ce_n)
    else $error("strobe without chip enable");
  a_re_release: assert property (!re_n |-> !io_oe)
    else $error("host drives bus during read");
  a_erase_pad: assert property (s_third_addr |-> io_oe && io_out[7:2] == 6'h00)
    else $error("last erase address not padded");
  a_confirm_order: assert property (cle && !we_n && io_out == CMD_ERASE_CONFIRM |->
    na_q == 2'h3 && cmd_q == CMD_ERASE_SETUP)
    else $error("confirm not after setup and three addresses");
  a_sig_addr: assert property (ale && !we_n && cmd_q == CMD_SIGNATURE |->
    io_out == SIG_ADDR && na_q == 2'h0)
    else $error("signature address wrong");
endmodule : nfc_ctrl_props
bind nfc_ctrl nfc_ctrl_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (.core_clk, .rst,
  .reg_rd, .reg_rdata, .io_out, .io_oe, .cle, .ale, .ce_n, .we_n, .re_n);

// ### testbench/nfc_flash_model.sv
// Behavioural flash device for erase, reset, status and signature commands.
module nfc_flash_model #(
  parameter int ERASE_NS = 3000,
  parameter int SLOW_NS = 40000,
  parameter int RST_NS = 500,
  parameter int RST_ERASE_NS = 2000,
  parameter logic [7:0] MAKER = 8'ha5, // Arbitrary value.
  parameter logic [7:0] DEV = 8'h3c // Arbitrary value.
) (
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic [7:0] io_h,
  output logic [7:0] io_d,
  output logic rb,
  input wire logic prot,
  input wire logic bad,
  input wire logic slow,
  output logic [23:0] addr_q,
  output int n_ers,
  output int n_rst
);
  timeunit 1ns;
  timeprecision 1ps;
  import nfc_pkg::*;
  logic [7:0] cmd = 8'h00;
  logic [7:0] last_v = 8'h00;
  logic busy = 1'b0;
  logic fail = 1'b0;
  logic in_rst = 1'b0;
  logic erasing = 1'b0;
  int na = 0;
  int nr = 0;
  int gen = 0;
  // Status tracks the engine live; reserved bits carry a pattern on purpose.
  wire logic [7:0] st = {~prot, ~busy, 5'h15, fail};
  wire logic [7:0] rd_v = cmd == CMD_STATUS ? st : nr == 1 ? MAKER : nr == 2 ? DEV : ~last_v;
  // A released bus shows the inverse of the last byte.
  assign io_d = (!ce_n && !re_n) ? rd_v : ~last_v;
  initial begin
    rb = 1'b1;
    addr_q = 24'h0;
    n_ers = 0;
    n_rst = 0;
  end
  always @(posedge re_n) last_v = rd_v;
  always @(negedge re_n) if (!ce_n && cmd == CMD_SIGNATURE) nr++;
  // Latches commands and addresses on the rising write strobe.
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      cmd = io_h;
      na = 0;
      nr = 0;
      if (io_h == CMD_RESET) begin
        if (!in_rst) fork do_reset(); join_none
      end else begin
        // Any other code, the legacy copy-back confirm included, is taken quietly.
        in_rst = 1'b0;
        if (io_h == CMD_ERASE_CONFIRM && !prot && !busy) fork do_erase(); join_none
      end
    end else if (!ce_n && ale) begin
      if (na < 3) addr_q[na*8 +: 8] = io_h;
      na++;
    end
  end
  task automatic do_erase();
    int my;
    gen++;
    my = gen;
    busy = 1'b1;
    erasing = 1'b1;
    rb = 1'b0;
    #(slow ? SLOW_NS : ERASE_NS);
    if (my == gen) begin
      fail = bad;
      n_ers++;
      erasing = 1'b0;
      busy = 1'b0;
      rb = 1'b1;
    end
  endtask : do_erase
  task automatic do_reset();
    gen++;
    n_rst++;
    in_rst = 1'b1;
    fail = 1'b0;
    busy = 1'b1;
    rb = 1'b0;
    #(erasing ? RST_ERASE_NS : RST_NS);
    erasing = 1'b0;
    busy = 1'b0;
    rb = 1'b1;
  endtask : do_reset
endmodule : nfc_flash_model

// ### testbench/nfc_ctrl_bench.sv
// Self-checking bench for the flash host controller.
module nfc_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import nfc_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic prot = 1'b0;
  logic bad = 1'b0;
  logic slow = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, rv;
  logic [7:0] io_out, io_d;
  logic [23:0] addr_q;
  logic io_oe, cle, ale, ce_n, we_n, re_n, rb;
  wire logic [7:0] io_in = io_oe ? io_out : io_d;
  int errors = 0;
  int num_checks = 0;
  int n_ers, n_rst;
  nfc_ctrl #(.TIMEOUT_CYCLES(2000)) uut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .io_in, .io_out, .io_oe, .cle, .ale, .ce_n, .we_n, .re_n, .rb);
  nfc_flash_model u_flash (.ce_n, .cle, .ale, .we_n, .re_n, .io_h(io_out), .io_d, .rb,
    .prot, .bad, .slow, .addr_q, .n_ers, .n_rst);
  initial forever #5 core_clk = ~core_clk;
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd
  // Polls the busy bit, or waits for a ready line level when rb_lvl is given.
  task automatic wait_for(int lim, int rb_lvl);
    int i;
    for (i = 0; i < lim; i++) begin
      if (rb_lvl < 0) rd(REG_STATUS);
      else @(posedge core_clk);
      if (rb_lvl < 0 ? rv[0] === 1'b0 : rb === rb_lvl[0]) break;
    end
    if (i == lim) begin
      errors++;
      $display("[ERR] wait ran out");
      wrap_up();
    end
  endtask : wait_for
  task automatic run_op(logic [1:0] op);
    wr(REG_CTRL, {30'h0, op});
    wait_for(4000, -1);
  endtask : run_op
  task automatic t_sig();
    rd(4'hf);
    check("unmapped", rv, 32'h0);
    run_op(OP_SIGNATURE);
    rd(REG_IDENT);
    check("ident", rv, {16'h0, u_flash.DEV, u_flash.MAKER});
    check("sig addr", addr_q[7:0], SIG_ADDR);
    $display("test signature done");
  endtask : t_sig
  task automatic t_erase(logic [11:0] blk, logic p, logic b);
    int e;
    e = n_ers;
    @(posedge core_clk);
    prot <= p;
    bad <= b;
    wr(REG_BLOCK, {20'h0, blk});
    wr(REG_CTRL, {30'h0, OP_ERASE});
    if (!p) begin
      wait_for(100, 0);
      rd(REG_STATUS);
      check("busy in erase", rv[0], 1'b1);
      wr(REG_BLOCK, {20'h0, ~blk});
    end
    wait_for(4000, -1);
    rd(REG_BLOCK);
    check("block kept", rv, {20'h0, blk});
    check("erase addr", addr_q, {7'h0, blk[11], blk[10:3], blk[2:0], 5'h0});
    check("erase count", n_ers, e + (p ? 0 : 1));
    run_op(OP_STATUS);
    rd(REG_RESULT);
    check("status", {rv[7:6], rv[0]}, {~p, 1'b1, b & ~p});
    rd(REG_STATUS);
    check("stat", rv[2:0], {1'b0, p | b, 1'b0});
    $display("test erase done");
  endtask : t_erase
  task automatic t_reset();
    int n;
    n = n_rst;
    run_op(OP_RESET);
    run_op(OP_RESET);
    check("reset count", n_rst, n + 1);
    run_op(OP_STATUS);
    rd(REG_RESULT);
    check("status after reset", {rv[6], rv[0]}, 2'b10);
    $display("test reset done");
  endtask : t_reset
  task automatic t_timeout();
    @(posedge core_clk);
    slow <= 1'b1;
    wr(REG_CTRL, {30'h0, OP_ERASE});
    wait_for(4000, -1);
    rd(REG_STATUS);
    check("timeout", rv[2], 1'b1);
    slow <= 1'b0;
    wait_for(6000, 1);
    $display("test timeout done");
  endtask : t_timeout
  // The rising reset edge at time zero puts every flop in its idle state at once.
  initial begin
    rst <= 1'b1;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_sig();
    t_erase(12'hfff, 1'b0, 1'b0);
    t_erase(12'h800, 1'b1, 1'b0);
    t_erase(12'h001, 1'b0, 1'b1);
    t_reset();
    t_timeout();
    wrap_up();
  end
endmodule : nfc_ctrl_bench
